// ### rtl/pmcr_pkg.sv
/*
 * Constants shared by the power and memory configuration register block:
 * register addresses, bit positions, reset values and address limits.
 * Assumes an 8-bit internal register space with 8-bit data.
 */
package pmcr_pkg;

    // Register addresses in the internal register space.
    localparam logic [7:0] PMCR_ADDR_POWER_CONTROL = 8'h87;
    localparam logic [7:0] PMCR_ADDR_MEMORY_CONFIG = 8'haf;
    localparam logic [7:0] PMCR_ADDR_STACK_HIGH    = 8'hb7;

    // Reset values.
    localparam logic [7:0] PMCR_RESET_BYTE   = 8'h00;
    localparam logic [2:0] PMCR_RESET_STACK_HIGH = 3'h0;
    localparam logic [7:0] PMCR_RESET_SP     = 8'h07;

    // Power control bit positions.
    localparam int PMCR_PC_BAUD_DOUBLE   = 7;
    localparam int PMCR_PC_SERIAL_WAKE   = 6;
    localparam int PMCR_PC_INT0_WAKE     = 5;
    localparam int PMCR_PC_STROBE_OFF    = 4;
    localparam int PMCR_PC_USER_FLAG_ONE = 3;
    localparam int PMCR_PC_USER_FLAG_ZERO = 2;
    localparam int PMCR_PC_POWER_DOWN    = 1;

    // Writable bit masks; other bits ignore writes and read as zero.
    localparam logic [7:0] PMCR_PC_WRITE_MASK = 8'hfe;
    localparam logic [7:0] PMCR_MC_WRITE_MASK = 8'h81;

    // Memory configuration bit positions.
    localparam int PMCR_MC_EXT_STACK = 7;
    localparam int PMCR_MC_EXTENDED_RAM_MAP  = 0;

    // Stack pointer and extended data address geometry.
    localparam int PMCR_STACK_HIGH_WIDTH = 3;
    localparam int PMCR_SP_WIDTH  = 11;
    localparam logic [23:0] PMCR_EXTENDED_RAM_TOP = 24'h0007ff;

    // Stack pointer step commands from the core.
    typedef enum logic [1:0] {
        PMCR_SP_HOLD = 2'b00,
        PMCR_SP_INC  = 2'b01,
        PMCR_SP_DEC  = 2'b10
    } pmcr_sp_op_t;

endpackage

// ### rtl/pmcr_wake_detect.sv
/*
 * Wake detector for power-down: synchronises the external interrupt 0 pin
 * and raises a wake request from the pin or from a serial interrupt.
 * Assumes the serial interrupt comes from logic on the same clock.
 */
`timescale 1ns/1ps

module pmcr_wake_detect (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ext_int0_n,
    input  wire logic ext_int0_trigger_type,
    input  wire logic serial_irq,
    input  wire logic serial_wake_enable,
    input  wire logic ext_int0_wake_enable,
    output logic      wake
);
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;
    logic int0_low;
    logic int0_fall;
    logic int0_hit;

    // Two-stage synchroniser and a delayed copy for edge detection.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
            prev_reg  <= 1'b1;
        end else begin
            sync1_reg <= ext_int0_n;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    // Level or falling edge depending on the trigger type.
    assign int0_low  = !sync2_reg;
    assign int0_fall = prev_reg && !sync2_reg;
    assign int0_hit  = ext_int0_trigger_type ? int0_fall : int0_low; // [RULE3]
    assign wake      = (ext_int0_wake_enable && int0_hit)             // [RULE3]
                     || (serial_wake_enable && serial_irq);           // [RULE2]

endmodule // pmcr_wake_detect

// ### rtl/pmcr_regs.sv
/*
 * Power control and memory configuration registers, the extended stack
 * pointer and the extended data address steering.
 * Assumes a core on the same clock issuing one-cycle register strobes.
 */
`timescale 1ns/1ps

// What this block does
// [RULE1] Power control bit 7 drives the UART baud doubling output.
// [RULE2] With bit 6 set, an SPI or I2C serial interrupt ends power-down.
// [RULE3] With bit 5 set, external interrupt 0 ends power-down, by low level or falling edge.
// [RULE4] Bit 4 set turns off the address latch strobe output.
// [RULE5] Bits 3 and 2 are user flags that only store what is written.
// [RULE6] Writing 1 to bit 1 puts the device into power-down.
// [RULE7] Power control bit 0 and memory configuration bits 6 to 1 ignore writes.
// [RULE8] Power control sits at 87H, resets to 00H and has no bit access.
// [RULE9] With the extended stack on, the 11-bit pointer steps from 00FFH to 0100H.
// [RULE10] With it off, the high byte is disabled and the pointer wraps FFH to 00H.
// [RULE11] With bit 0 set, internal extended RAM answers the lowest 2 kbytes.
// [RULE12] With bit 0 clear, extended accesses go to the external space of up to 16 MB.
// [RULE13] The memory configuration register resets to 00H.
// [RULE14] With the extended stack off, the high byte ignores writes and reads as zero.
// [RULE15] Addresses above 0007FFH always go off-chip.
// [RULE16] An enabled wake source clears the power-down request and resumes operation.
module pmcr_regs
    import pmcr_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [7:0]          reg_rdata,
    output logic                     reg_hit,
    input  wire pmcr_pkg::pmcr_sp_op_t sp_op,
    output logic      [10:0]         stack_pointer,
    input  wire logic [23:0]         data_pointer,
    output logic                     extended_ram_internal_sel,
    output logic                     extended_ram_external_sel,
    input  wire logic                ext_int0_n,
    input  wire logic                ext_int0_trigger_type,
    input  wire logic                serial_irq,
    output logic                     baud_double,
    output logic                     latch_strobe_enable,
    output logic                     power_down,
    output logic                     wake_event
);
    import pmcr_pkg::*;

    logic [7:0]  power_control_reg;
    logic [7:0]  power_control_next;
    logic [7:0]  memory_config_reg;
    logic [7:0]  memory_config_next;
    logic [10:0] sp_reg;
    logic [10:0] sp_next;
    logic [7:0]  rdata_reg;
    logic        wake;
    logic        sel_pc;
    logic        sel_mc;
    logic        sel_stack_high;
    logic        ext_stack;
    logic [10:0] sp_step;
    logic [7:0]  rdata_next;

    // Merge a written byte under a mask, keeping unmasked bits.
    function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                         input logic [7:0] mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    // Address decode, whole-byte access only.
    assign sel_pc    = (reg_addr == PMCR_ADDR_POWER_CONTROL); // [RULE8]
    assign sel_mc    = (reg_addr == PMCR_ADDR_MEMORY_CONFIG);
    assign sel_stack_high = (reg_addr == PMCR_ADDR_STACK_HIGH);
    assign ext_stack      = memory_config_reg[PMCR_MC_EXT_STACK];
    assign reg_hit        = sel_pc || sel_mc || (sel_stack_high && ext_stack); // [RULE14]

    pmcr_wake_detect u_wake (
        .clk                   (clk),
        .rst_n                 (rst_n),
        .ext_int0_n            (ext_int0_n),
        .ext_int0_trigger_type (ext_int0_trigger_type),
        .serial_irq            (serial_irq),
        .serial_wake_enable    (power_control_reg[PMCR_PC_SERIAL_WAKE]),
        .ext_int0_wake_enable  (power_control_reg[PMCR_PC_INT0_WAKE]),
        .wake                  (wake)
    );

    // Power control next value; a wake while asleep clears the request.
    always_comb begin
        power_control_next = power_control_reg;
        if (reg_wr && sel_pc) begin
            power_control_next = merge(power_control_reg, reg_wdata,
                                       PMCR_PC_WRITE_MASK); // [RULE5] [RULE7]
        end
        if (power_control_reg[PMCR_PC_POWER_DOWN] && wake) begin
            power_control_next[PMCR_PC_POWER_DOWN] = 1'b0; // [RULE16]
        end
    end

    // Memory configuration next value, only bits 7 and 0 are stored.
    assign memory_config_next = (reg_wr && sel_mc)
        ? merge(memory_config_reg, reg_wdata, PMCR_MC_WRITE_MASK) // [RULE7]
        : memory_config_reg;

    // Stack step: 11 bits with the extended stack, else the low byte wraps.
    assign sp_step = (sp_op == PMCR_SP_INC) ? sp_reg + 11'h001
                   : (sp_op == PMCR_SP_DEC) ? sp_reg - 11'h001 : sp_reg;

    always_comb begin
        sp_next = sp_reg;
        if (ext_stack) begin
            sp_next = sp_step; // [RULE9]
        end else begin
            sp_next = {sp_reg[10:8], sp_step[7:0]}; // [RULE10]
        end
        if (reg_wr && sel_stack_high && ext_stack) begin
            sp_next[10:8] = reg_wdata[PMCR_STACK_HIGH_WIDTH-1:0]; // [RULE14]
        end
    end

    // Read data: unmapped and disabled high byte read as zero.
    always_comb begin
        rdata_next = PMCR_RESET_BYTE;
        if (sel_pc) begin
            rdata_next = power_control_reg;
        end else if (sel_mc) begin
            rdata_next = memory_config_reg;
        end else if (sel_stack_high && ext_stack) begin
            rdata_next = {5'h00, sp_reg[10:8]}; // [RULE14]
        end
    end

    // Register state.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_control_reg <= PMCR_RESET_BYTE; // [RULE8]
            memory_config_reg <= PMCR_RESET_BYTE; // [RULE13]
            sp_reg            <= {PMCR_RESET_STACK_HIGH, PMCR_RESET_SP};
            rdata_reg         <= PMCR_RESET_BYTE;
        end else begin
            power_control_reg <= power_control_next;
            memory_config_reg <= memory_config_next;
            sp_reg            <= sp_next;
            rdata_reg         <= reg_rd ? rdata_next : rdata_reg;
        end
    end

    // Outputs derived from register bits and the wake request.
    assign reg_rdata           = rdata_reg;
    assign baud_double         = power_control_reg[PMCR_PC_BAUD_DOUBLE];  // [RULE1]
    assign latch_strobe_enable = !power_control_reg[PMCR_PC_STROBE_OFF];  // [RULE4]
    assign power_down          = power_control_reg[PMCR_PC_POWER_DOWN];   // [RULE6]
    assign wake_event          = power_down && wake;                      // [RULE16]
    assign stack_pointer       = ext_stack ? sp_reg : {3'h0, sp_reg[7:0]}; // [RULE10]

    // Internal RAM only when mapped and within the lowest 2 kbytes.
    assign extended_ram_internal_sel = memory_config_reg[PMCR_MC_EXTENDED_RAM_MAP]
                             && (data_pointer <= PMCR_EXTENDED_RAM_TOP);  // [RULE11] [RULE15]
    assign extended_ram_external_sel = !extended_ram_internal_sel;                // [RULE12]

endmodule // pmcr_regs

// ### verification/pmcr_regs_sva.sv
/* Checker for pmcr_regs, watching its ports only.
   Assumes the bind below and the pmcr_pkg constants. */
`timescale 1ns/1ps
module pmcr_regs_chk
    import pmcr_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire pmcr_sp_op_t sp_op,
    input wire logic [10:0] stack_pointer,
    input wire logic [23:0] data_pointer,
    input wire logic        extended_ram_internal_sel,
    input wire logic        extended_ram_external_sel,
    input wire logic        baud_double,
    input wire logic        latch_strobe_enable,
    input wire logic        power_down,
    input wire logic        wake_event
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic ext_q;
    // Writes to the power control and memory configuration registers, decoded from the strobe and address.
    wire wr_pc = reg_wr && reg_addr == PMCR_ADDR_POWER_CONTROL;
    wire wr_mc = reg_wr && reg_addr == PMCR_ADDR_MEMORY_CONFIG;
    wire inc = sp_op == PMCR_SP_INC && !reg_wr;
    // Shadow of the extended stack enable, to know how the pointer must step.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) ext_q <= 1'b0;
        else if (wr_mc) ext_q <= reg_wdata[7];
    end
    property p_baud; wr_pc |=> baud_double == $past(reg_wdata[7]); endproperty
    a_baud: assert property (p_baud) else $error("baud bit mismatch");
    property p_ale; wr_pc |=> latch_strobe_enable == !$past(reg_wdata[4]); endproperty
    a_ale: assert property (p_ale) else $error("strobe enable mismatch");
    property p_power_down; wr_pc && reg_wdata[1] && !wake_event |=> power_down; endproperty
    a_power_down: assert property (p_power_down) else $error("power down not entered");
    property p_wake; wake_event |-> power_down ##1 !power_down; endproperty
    a_wake: assert property (p_wake) else $error("wake did not end power down");
    property p_mc; reg_rd && reg_addr == PMCR_ADDR_MEMORY_CONFIG |=> reg_rdata[6:1] == 6'h00; endproperty
    a_mc: assert property (p_mc) else $error("unused config bits read back");
    property p_stack_high; reg_rd && reg_addr == PMCR_ADDR_STACK_HIGH && !ext_q |=> reg_rdata == 8'h00; endproperty
    a_stack_high: assert property (p_stack_high) else $error("disabled stack high read back");
    property p_wrap; !ext_q && inc && stack_pointer == 11'h0ff |=> stack_pointer == 11'h000; endproperty
    a_wrap: assert property (p_wrap) else $error("short stack did not wrap");
    property p_ext; ext_q && inc && stack_pointer == 11'h0ff |=> stack_pointer == 11'h100; endproperty
    a_ext: assert property (p_ext) else $error("long stack did not carry");
    property p_off; data_pointer > 24'h0007ff |-> extended_ram_external_sel && !extended_ram_internal_sel; endproperty
    a_off: assert property (p_off) else $error("high address not sent off chip");
endmodule // pmcr_regs_chk
bind pmcr_regs pmcr_regs_chk u_pmcr_regs_chk (.*);

// ### verification/tb_top.sv
/* Testbench for pmcr_regs: registers, stack pointer, steering and wake.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
module tb_top;
    import pmcr_pkg::*;
    logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, ext_int0_n = 1;
    logic ext_int0_trigger_type = 0, serial_irq = 0, reg_hit, extended_ram_internal_sel;
    logic extended_ram_external_sel, baud_double, latch_strobe_enable, power_down, wake_event;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
    logic [10:0] stack_pointer;
    logic [23:0] data_pointer = 0;
    pmcr_sp_op_t sp_op = PMCR_SP_HOLD;
    int miscompares = 0, checked = 0;
    logic seen;
    logic [23:0] dps [4] = '{24'h000000, 24'h0007ff, 24'h000800, 24'hffffff};
    logic [7:0] wpc [5] = '{8'h22, 8'h22, 8'h42, 8'h02, 8'h42};
    logic [4:0] wtt = 5'b00010, wser = 5'b01100, wexp = 5'b00111;
    pmcr_regs u_pmcr_regs (.*);
    // Free-running clock at 40 ns.
    initial forever #20 clk = ~clk;
    task cmp(input string n, input logic [10:0] e, input logic [10:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a; reg_wdata = d; reg_wr = 1;
        @(negedge clk); reg_wr = 0;
        @(negedge clk);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr = a; reg_rd = 1;
        @(negedge clk); reg_rd = 0;
        cmp("reg_rdata", {3'h0, e}, {3'h0, reg_rdata});
        @(negedge clk);
    endtask
    task step(input pmcr_sp_op_t op, input int n);
        sp_op = op;
        repeat (n) @(negedge clk);
        sp_op = PMCR_SP_HOLD;
    endtask
    task results;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Main sequence; every input changes at the falling edge.
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1;
        @(negedge clk);
        rd(8'h87, 8'h00);
        cmp("hit", 11'h1, {10'h0, reg_hit});
        rd(8'haf, 8'h00);
        rd(8'hb7, 8'h00);
        cmp("hit", 11'h0, {10'h0, reg_hit});
        rd(8'h55, 8'h00);
        cmp("hit", 11'h0, {10'h0, reg_hit});
        cmp("sp", 11'h007, stack_pointer);
        cmp("ale", 11'h1, {10'h0, latch_strobe_enable});
        $display("reset test done");
        wr(8'h87, 8'hff);
        cmp("pd", 11'h1, {10'h0, power_down});
        cmp("baud", 11'h1, {10'h0, baud_double});
        cmp("ale", 11'h0, {10'h0, latch_strobe_enable});
        rd(8'h87, 8'hfe);
        wr(8'h87, 8'h0c);
        rd(8'h87, 8'h0c);
        cmp("baud", 11'h0, {10'h0, baud_double});
        wr(8'haf, 8'hff);
        rd(8'haf, 8'h81);
        wr(8'hb7, 8'hff);
        rd(8'hb7, 8'h07);
        cmp("hit", 11'h1, {10'h0, reg_hit});
        cmp("sp", 11'h707, stack_pointer);
        wr(8'haf, 8'h00);
        cmp("sp", 11'h007, stack_pointer);
        wr(8'hb7, 8'h03);
        rd(8'hb7, 8'h00);
        cmp("hit", 11'h0, {10'h0, reg_hit});
        $display("register test done");
        step(PMCR_SP_INC, 248);
        cmp("sp", 11'h0ff, stack_pointer);
        step(PMCR_SP_INC, 1);
        cmp("sp", 11'h000, stack_pointer);
        wr(8'haf, 8'h80);
        wr(8'hb7, 8'h00);
        step(PMCR_SP_INC, 256);
        cmp("sp", 11'h100, stack_pointer);
        step(PMCR_SP_DEC, 1);
        cmp("sp", 11'h0ff, stack_pointer);
        $display("stack test done");
        for (int m = 0; m < 2; m++) begin
            wr(8'haf, {7'h0, m[0]});
            for (int i = 0; i < 4; i++) begin
                data_pointer = dps[i];
                @(negedge clk);
                cmp("int_sel", {10'h0, m[0] && i < 2}, {10'h0, extended_ram_internal_sel});
                cmp("ext_sel", {10'h0, !(m[0] && i < 2)}, {10'h0, extended_ram_external_sel});
            end
        end
        $display("steering test done");
        for (int c = 0; c < 5; c++) begin
            ext_int0_trigger_type = wtt[c];
            wr(8'h87, wpc[c]);
            cmp("pd", 11'h1, {10'h0, power_down});
            if (wser[c]) serial_irq = 1;
            else ext_int0_n = 0;
            seen = 1'b0;
            // Watch for the wake pulse while waiting for power-down to end.
            for (int i = 0; i < 10 && power_down === 1'b1; i++) begin
                #1 seen = seen | wake_event;
                @(negedge clk);
            end
            cmp("pd", {10'h0, !wexp[c]}, {10'h0, power_down});
            cmp("wake", {10'h0, wexp[c]}, {10'h0, seen});
            if (wexp[c] && power_down !== 1'b0) results();
            serial_irq = 0;
            ext_int0_n = 1;
            repeat (4) @(negedge clk);
        end
        $display("wake test done");
        results();
    end
endmodule // tb_top
